//--- core/fct_clock_timing.v
// fct_clock_timing.v: clock derivation, oscillator sync, one-second timer,
// frame pulse and recovered clock selection of a framer channel set.
// assumes an APB master on ref_clk; line clocks and pins arrive async.
//
// Functional notes
// - every internal clock here is derived from the master reference.
// - a detected sync clock steers the receive oscillator to lock to it.
// - in master mode with 8 kHz sync selected, the oscillator follows 8 kHz.
// - an input pulse high for two 2.048 MHz cycles triggers the timer.
// - the second pin is an input after reset; misc config sets direction.
// - as output the second pin is high two 2.048 MHz cycles each second.
// - the frame pulse repeats at 8 kHz, one 2.048 MHz cycle, any polarity.
// - the recovered clock pin is undriven after reset until enabled.
// - source 00 gives the line clock, or a reference clock on signal loss.
// - source 01 gives the line clock, held high during signal loss.
// - source 11 gives the oscillator clock, 8.192 or 6.176 MHz.
// - a route field picks which channel's line clock feeds pin one.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "fct_regs.vh"
module fct_clock_timing (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // external timing pins
  input wire sync_in,
  input wire one_second_pin_in,
  output reg one_second_pin_out,
  output reg one_second_pin_oe,
  output reg frame_pulse_8k,
  // line side
  input wire [3:0] line_clk,
  input wire signal_loss_flag,
  // recovered clock pin of channel one
  output reg recclk_out,
  output reg recclk_output_enable
);
  reg [31:0] ctrl;
  reg [31:0] recclk;
  reg [31:0] misc_pin_config;
  reg [31:0] clock_synth_config;
  reg [3:0] line_s1, line_s2;
  reg sync_s1, sync_s2, sync_s3;
  reg sec_s1, sec_s2;
  reg los_s1, los_s2;
  reg [15:0] sync_age;
  reg sync_detected;
  reg [31:0] osc_step;
  reg [11:0] sec_hi_ticks;
  reg sec_armed;
  reg sec_event;
  reg sec_seen;
  reg [21:0] sec_cnt;
  reg [1:0] sec_pulse;
  reg [7:0] frame_cnt;
  reg fallback_clk;
  reg [7:0] fallback_cnt;
  reg [31:0] next_prdata;
  reg next_rec;
  wire tick_2m;
  wire osc_square;
  wire osc_tick;
  wire [1:0] src = recclk[`FCT_REC_SRC_LO +: 2];
  wire [1:0] route = misc_pin_config[`FCT_MISC_ROUTE_LO +: 2];
  wire sec_is_out = misc_pin_config[`FCT_MISC_SECOUT];
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sel_line = line_s2[route];
  // a status read clears the sticky second event at its setup edge
  wire st_rd = psel && !penable && !pwrite && paddr == `FCT_OFF_STATUS;
  wire sync_8k = ctrl[`FCT_CTRL_SYNC8K] && ctrl[`FCT_CTRL_MASTER];
  wire [15:0] sync_limit = sync_8k ? `FCT_SYNC8K_TIMEOUT : `FCT_SYNC_TIMEOUT;

  function [31:0] step_for;
    input [31:0] khz;
    reg [63:0] scaled;
    begin
      // widen first: a kHz rate shifted by 32 does not fit a word
      scaled = {32'h0000_0000, khz} << 32;
      scaled = scaled / (`FCT_CLK_MHZ * 1000);
      step_for = scaled[31:0];
    end
  endfunction

  // accumulator steps of the fixed tick and of the oscillator rates
  localparam [31:0] STEP_TICK = step_for(`FCT_TICK_KHZ);
  localparam [31:0] STEP_E1 = step_for(32'd8192);
  localparam [31:0] STEP_T1 = step_for(32'd6176);

  // fixed 2.048 MHz timebase from ref_clk
  fct_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .step(STEP_TICK),
    .tick(tick_2m),
    .square()
  );

  // receive oscillator, nominal rate steered by sync edges
  fct_tick_gen u_osc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .step(osc_step),
    .tick(osc_tick),
    .square(osc_square)
  );

  // apb register writes
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `FCT_CTRL_RST;
      recclk <= `FCT_REC_RST;
      misc_pin_config <= `FCT_MISC_RST;
      clock_synth_config <= `FCT_SYNTH_RST;
    end else if (wr) begin
      // writes to unmapped offsets are dropped
      case (paddr)
        `FCT_OFF_CTRL: ctrl <= {26'h0, pwdata[5:0]};
        `FCT_OFF_RECCLK: recclk <= {29'h0, pwdata[2:0]};
        `FCT_OFF_MISC: misc_pin_config <= {29'h0, pwdata[2:0]};
        `FCT_OFF_SYNTH: clock_synth_config <= {24'h0, pwdata[7:0]};
        default: ctrl <= ctrl;
      endcase
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `FCT_OFF_CTRL: next_prdata = ctrl;
      `FCT_OFF_RECCLK: next_prdata = recclk;
      `FCT_OFF_MISC: next_prdata = misc_pin_config;
      `FCT_OFF_SYNTH: next_prdata = clock_synth_config;
      // status: sync seen, sticky second event, loss of signal
      `FCT_OFF_STATUS: next_prdata = {29'h0, los_s2, sec_seen,
        sync_detected};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // no wait state: pready rises in the first access cycle
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'h0 ||
        paddr > `FCT_OFF_STATUS);
      if (psel && !penable && !pwrite)
        prdata <= next_prdata;
    end
  end

  // input synchronisers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line_s1 <= 4'h0;
      line_s2 <= 4'h0;
      // sync and second pins idle high, so no false edge follows reset
      sync_s1 <= 1'b1;
      sync_s2 <= 1'b1;
      sync_s3 <= 1'b1;
      sec_s1 <= 1'b1;
      sec_s2 <= 1'b1;
      los_s1 <= 1'b0;
      los_s2 <= 1'b0;
    end else begin
      line_s1 <= line_clk;
      line_s2 <= line_s1;
      sync_s1 <= sync_in;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      sec_s1 <= one_second_pin_in;
      sec_s2 <= sec_s1;
      los_s1 <= signal_loss_flag;
      los_s2 <= los_s1;
    end
  end

  // sync clock detection and oscillator steering
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_age <= 16'h0000;
      sync_detected <= 1'b0;
      osc_step <= STEP_E1;
    end else begin
      if (sync_s2 && !sync_s3) begin
        sync_age <= 16'h0000;
        sync_detected <= 1'b1;
      end else if (sync_age >= sync_limit) begin
        // 8 kHz edges come once a frame, so that mode lapses later
        sync_detected <= 1'b0;
      end else begin
        sync_age <= sync_age + 16'h0001;
      end
      // oscillator rate follows mode; a sync edge nudges phase lock
      if (ctrl[`FCT_CTRL_T1] && ctrl[`FCT_CTRL_SSC])
        osc_step <= STEP_T1;
      else
        osc_step <= STEP_E1;
      if (sync_detected && !ctrl[`FCT_CTRL_OSCDIS] && sync_s2 && !sync_s3 &&
          (!ctrl[`FCT_CTRL_SYNC8K] || ctrl[`FCT_CTRL_MASTER]))
        osc_step <= osc_step + {31'h0, !osc_square};
    end
  end

  // one-second timer, pin as input or output
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sec_hi_ticks <= 12'h000;
      // armed only once the pin was seen low, not by the idle pull-up
      sec_armed <= 1'b0;
      sec_event <= 1'b0;
      sec_cnt <= 22'h000000;
      sec_pulse <= 2'h0;
    end else begin
      sec_event <= 1'b0;
      if (!sec_s2) begin
        sec_hi_ticks <= 12'h000;
        sec_armed <= 1'b1;
      end else if (tick_2m && sec_hi_ticks != 12'hfff) begin
        sec_hi_ticks <= sec_hi_ticks + 12'h001;
      end
      if (tick_2m) begin
        if (sec_pulse != 2'h0)
          sec_pulse <= sec_pulse - 2'h1;
        if (sec_cnt == `FCT_SEC_TICKS - 1) begin
          sec_cnt <= 22'h000000;
          sec_event <= 1'b1;
          sec_pulse <= `FCT_SEC_PULSE_TICKS;
        end else begin
          sec_cnt <= sec_cnt + 22'h000001;
        end
      end
      if (!sec_is_out && sec_armed && sec_hi_ticks >= 12'h002) begin
        sec_armed <= 1'b0;
        sec_cnt <= 22'h000000;
        sec_event <= 1'b1;
      end
    end
  end

  // sticky second event for software; on a clash with a status read
  // the new event wins and is kept for the next read
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      sec_seen <= 1'b0;
    else if (sec_event)
      sec_seen <= 1'b1;
    else if (st_rd)
      sec_seen <= 1'b0;
  end

  // pin drivers, frame pulse and recovered clock
  always @* begin
    case (src)
      `FCT_SRC_LINE_HI: next_rec = los_s2 ? 1'b1 : sel_line;
      `FCT_SRC_OSC: next_rec = osc_square;
      default: next_rec = los_s2 ? fallback_clk : sel_line;
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frame_cnt <= 8'h00;
      frame_pulse_8k <= 1'b0;
      one_second_pin_out <= 1'b0;
      one_second_pin_oe <= 1'b0;
      recclk_out <= 1'b1;
      recclk_output_enable <= 1'b0;
      fallback_clk <= 1'b0;
      fallback_cnt <= 8'h00;
    end else begin
      if (tick_2m)
        frame_cnt <= frame_cnt + 8'h01;
      if (tick_2m)
        frame_pulse_8k <= (frame_cnt == 8'hff) ^ ctrl[`FCT_CTRL_FPOL];
      else if (frame_cnt != 8'h00)
        frame_pulse_8k <= ctrl[`FCT_CTRL_FPOL];
      one_second_pin_oe <= sec_is_out;
      one_second_pin_out <= sec_is_out && sec_pulse != 2'h0;
      // fallback clock, half period set by the synthesis divider
      if (fallback_cnt >= clock_synth_config[7:0]) begin
        fallback_cnt <= 8'h00;
        fallback_clk <= !fallback_clk;
      end else begin
        fallback_cnt <= fallback_cnt + 8'h01;
      end
      // the pin stays undriven until software enables it
      recclk_output_enable <= recclk[`FCT_REC_OE];
      recclk_out <= next_rec;
    end
  end
endmodule // fct_clock_timing

//--- shared/fct_regs.vh
// fct_regs.vh: register offsets, field positions, reset values and timing
// counts of the framer clock and timing pin block.
// assumes a 250 MHz ref_clk and an APB slave with 32-bit word registers.
`ifndef FCT_REGS_VH
`define FCT_REGS_VH

// register byte offsets
`define FCT_OFF_CTRL 12'h000
`define FCT_OFF_RECCLK 12'h004
`define FCT_OFF_MISC 12'h008
`define FCT_OFF_SYNTH 12'h00c
`define FCT_OFF_STATUS 12'h010

// control register fields
`define FCT_CTRL_MASTER 0
`define FCT_CTRL_SYNC8K 1
`define FCT_CTRL_OSCDIS 2
`define FCT_CTRL_T1 3
`define FCT_CTRL_SSC 4
`define FCT_CTRL_FPOL 5
`define FCT_CTRL_RST 32'h0000_0000

// recovered clock register fields
`define FCT_REC_SRC_LO 0
`define FCT_REC_OE 2
`define FCT_REC_RST 32'h0000_0000

// misc pin config fields
`define FCT_MISC_SECOUT 0
`define FCT_MISC_ROUTE_LO 1
`define FCT_MISC_RST 32'h0000_0000

// clock synthesis: divide ratio of the master reference for los fallback
`define FCT_SYNTH_RST 32'h0000_0008

// status fields
`define FCT_ST_SYNCDET 0
`define FCT_ST_SECEV 1
`define FCT_ST_LOS 2

// recovered clock source codes
`define FCT_SRC_LINE 2'h0
`define FCT_SRC_LINE_HI 2'h1
`define FCT_SRC_RSVD 2'h2
`define FCT_SRC_OSC 2'h3

// timing: 2.048 MHz tick derived from 250 MHz, 8 kHz frame, one second
`define FCT_CLK_MHZ 250
`define FCT_TICK_KHZ 2048
`define FCT_TICK_DIV_W 32
`define FCT_FRAME_TICKS 256
`define FCT_SEC_TICKS 2048000
`define FCT_SEC_PULSE_TICKS 2'd2
`define FCT_SYNC_TIMEOUT 16'd2000
`define FCT_SYNC8K_TIMEOUT 16'd40000

`endif

//--- core/fct_tick_gen.v
// fct_tick_gen.v: phase accumulator that turns ref_clk into one-cycle
// ticks at an average rate of step/2^32 of the clock.
// assumes step is held steady by software or a constant.
`timescale 1ns/1ps
module fct_tick_gen (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // rate
  input wire [31:0] step,
  // tick and half-period square
  output reg tick,
  output reg square
);
  reg [31:0] acc;
  wire [32:0] sum = {1'b0, acc} + {1'b0, step};

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= 32'h0000_0000;
      tick <= 1'b0;
      square <= 1'b0;
    end else begin
      acc <= sum[31:0];
      tick <= sum[32];
      square <= sum[31];
    end
  end
endmodule // fct_tick_gen

//--- bench/fct_far_side.sv
// fct_far_side.sv: line clocks, sync reference and loss flag for the bench.
// assumes the bench raises its requests as levels.
`timescale 1ns/1ps
module fct_far_side (
  // requests from the bench
  input wire loss_req,
  input wire sync_on,
  input wire sec_lvl,
  // pins toward the block
  output logic [3:0] line_clk,
  output logic sync_in,
  output wire signal_loss_flag,
  output wire one_second_pin_in
);
  initial line_clk = 4'h0;
  initial sync_in = 1'b1;
  assign signal_loss_flag = loss_req;
  // second pin pulses shaped by the bench, idle high like the pull-up
  assign one_second_pin_in = sec_lvl;
  // no line pulses arrive while the signal is lost; edges stay off ref_clk
  always #40 if (!loss_req) line_clk[0] = ~line_clk[0];
  always #60 if (!loss_req) line_clk[1] = ~line_clk[1];
  always #80 if (!loss_req) line_clk[2] = ~line_clk[2];
  always #100 if (!loss_req) line_clk[3] = ~line_clk[3];
  // 2.048 MHz sync clock, pulled high while absent
  always #244 sync_in = sync_on ? ~sync_in : 1'b1;
endmodule // fct_far_side

//--- bench/fct_clock_timing_sva.sv
// fct_clock_timing_sva.sv: port assertions for the clock and timing block.
// assumes binding to fct_clock_timing; sees its ports only.
`timescale 1ns/1ps
module fct_clock_timing_sva (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  // pins
  input wire one_second_pin_oe,
  input wire frame_pulse_8k,
  input wire recclk_out,
  input wire recclk_output_enable
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  wire wr = psel && penable && pwrite && pready;
  reg fp_q;
  reg [15:0] fp_n;
  always @(posedge ref_clk)
    fp_q <= frame_pulse_8k;
  // cycles since the frame pin last changed, saturating
  always @(posedge ref_clk or negedge rstn)
    if (!rstn)
      fp_n <= 16'hffff;
    else
      fp_n <= (frame_pulse_8k != fp_q) ? 16'h1 :
        fp_n + {15'h0, fp_n != 16'hffff};
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_access ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("apb access not answered next cycle");
  property p_cause;
    $rose(pready) |-> $past(psel) && !$past(penable);
  endproperty
  a_cause: assert property (p_cause)
    else $error("pready without setup");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err)
    else $error("error flag outside access");
  property p_sp_rst;
    $rose(rstn) |-> !one_second_pin_oe;
  endproperty
  a_sp_rst: assert property (p_sp_rst)
    else $error("second pin not input after reset");
  property p_sp_dir;
    $changed(one_second_pin_oe) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_sp_dir: assert property (p_sp_dir)
    else $error("second pin direction moved without write");
  property p_rec_rst;
    $rose(rstn) |-> recclk_out && !recclk_output_enable;
  endproperty
  a_rec_rst: assert property (p_rec_rst)
    else $error("recovered clock driven after reset");
  property p_rec_dir;
    $changed(recclk_output_enable) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_rec_dir: assert property (p_rec_dir)
    else $error("recovered clock enable moved without write");
  property p_fp_width;
    $changed(frame_pulse_8k) && fp_n < 16'd1000 |->
      fp_n >= 16'd121 && fp_n <= 16'd124;
  endproperty
  a_fp_width: assert property (p_fp_width)
    else $error("frame pulse width wrong");
endmodule // fct_clock_timing_sva
bind fct_clock_timing fct_clock_timing_sva u_sva (.ref_clk(ref_clk),
  .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .one_second_pin_oe(one_second_pin_oe),
  .frame_pulse_8k(frame_pulse_8k), .recclk_out(recclk_out),
  .recclk_output_enable(recclk_output_enable));

//--- bench/fct_clock_timing_tb.sv
// fct_clock_timing_tb.sv: self-checking bench of the clock and timing block.
// assumes the far-side model and the checker are compiled with it.
`timescale 1ns/1ps
module fct_clock_timing_tb;
  logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rnd = 32'haa69, prdata;
  logic pready, pslverr, sync_in, sp_in, sp_out, sp_oe, fp, loss, rec, rec_oe;
  logic [3:0] line_clk;
  logic loss_req = 0, sync_on = 0, sec_lvl = 1;
  logic [64:0] expq[$], note;
  logic [31:0] msk[4] = '{32'h1f, 32'h7, 32'h7, 32'hff};
  int n_fail = 0, checked = 0, k, t1, t2;
  always #2 ref_clk = ~ref_clk; // steady master reference
  fct_clock_timing dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_in(sync_in),
    .one_second_pin_in(sp_in), .one_second_pin_out(sp_out),
    .one_second_pin_oe(sp_oe), .frame_pulse_8k(fp), .line_clk(line_clk),
    .signal_loss_flag(loss), .recclk_out(rec), .recclk_output_enable(rec_oe));
  fct_far_side far (.loss_req(loss_req), .sync_on(sync_on),
    .sec_lvl(sec_lvl), .line_clk(line_clk), .sync_in(sync_in),
    .signal_loss_flag(loss), .one_second_pin_in(sp_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task hang;
    n_fail++;
    $display("mismatch %0t wait ran out", $time);
    summarize;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50)
      hang;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic err,
    input logic [31:0] m);
    expq.push_back({m, err, e & m});
    apb(0, a, 0);
  endtask
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = expq.pop_front();
      chk({pslverr, prdata & note[64:33]}, note[32:0]);
    end
  task follow(input int r);
    int i, s;
    logic p;
    s = 0;
    p = line_clk[r];
    for (i = 0; i < 150; i++) begin
      @(posedge ref_clk);
      s = (line_clk[r] === p) ? s + 1 : 0;
      p = line_clk[r];
      if (s == 6)
        chk(rec, p);
    end
  endtask
  task edges(input int n, output int e);
    logic p;
    e = 0;
    p = rec;
    repeat (n) begin
      @(posedge ref_clk);
      e += int'(rec !== p);
      p = rec;
    end
  endtask
  task waitch(output int n);
    logic v;
    v = fp;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (fp === v && n < 40000);
    if (n >= 40000)
      hang;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1;
    chk({sp_oe, rec_oe, rec}, 3'b001);
    for (k = 0; k < 4; k++)
      rd(12'(k * 4), k == 3 ? 32'h8 : 32'h0, 0, '1);
    for (k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      apb(1, 12'(k * 4), rnd & msk[k]);
      rd(12'(k * 4), rnd, 0, msk[k]);
    end
    apb(1, 12'h014, rnd);
    rd(12'h014, 0, 1, 0);
    rd(12'h002, 0, 1, 0);
    apb(1, 12'h00c, 32'h8);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h008, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk({sp_oe, sp_out}, 2'b10);
    for (k = 0; k < 8; k++) begin
      apb(1, 12'h004, k > 3 ? 32'h6 : 32'h4);
      apb(1, 12'h008, 32'(k % 4) << 1);
      follow(k % 4);
    end
    chk(rec_oe, 1'b1);
    loss_req <= 1;
    apb(1, 12'h004, 32'h5);
    edges(10, t1);
    edges(100, t1);
    chk({t1 == 0, rec}, 2'b11);
    apb(1, 12'h004, 32'h4);
    edges(500, t1);
    chk(t1 >= 54 && t1 <= 57, 1'b1);
    loss_req <= 0;
    apb(1, 12'h004, 32'h7);
    edges(30, t1);
    edges(305, t1);
    chk(t1 >= 19 && t1 <= 21, 1'b1);
    apb(1, 12'h000, 32'h18);
    edges(30, t1);
    edges(405, t1);
    chk(t1 >= 19 && t1 <= 21, 1'b1);
    sync_on <= 1;
    repeat (200) @(posedge ref_clk);
    rd(12'h010, 1, 0, 1);
    sync_on <= 0;
    repeat (2300) @(posedge ref_clk);
    rd(12'h010, 0, 0, 1);
    rd(12'h010, 0, 0, 2);
    sec_lvl <= 0;
    repeat (100) @(posedge ref_clk);
    sec_lvl <= 1;
    repeat (60) @(posedge ref_clk);
    sec_lvl <= 0;
    repeat (100) @(posedge ref_clk);
    rd(12'h010, 0, 0, 2);
    sec_lvl <= 1;
    repeat (500) @(posedge ref_clk);
    rd(12'h010, 2, 0, 2);
    rd(12'h010, 0, 0, 2);
    waitch(t1);
    waitch(t1);
    waitch(t2);
    chk(t1 + t2 >= 31249 && t1 + t2 <= 31251, 1'b1);
    repeat (1300) @(posedge ref_clk);
    apb(1, 12'h000, 32'h20);
    repeat (3) @(posedge ref_clk);
    chk(fp, 1'b1);
    summarize;
  end
endmodule // fct_clock_timing_tb
